// >>> src/lbdac_pkg.sv
// Purpose: shared constants and types of the laser bias DAC control block
// Assumes: byte-wide serial registers, seven-bit register address
// Notes:   reset values of the six writable registers and field positions live here; status and pin reset values sit in lbdac_ctrl
package lbdac_pkg;

	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [6:0] LBDAC_TRANSMIT_CONTROL   = 7'h00;
	localparam logic [6:0] LBDAC_FAULT_STATUS_ONE   = 7'h01;
	localparam logic [6:0] LBDAC_FAULT_STATUS_TWO   = 7'h02;
	localparam logic [6:0] LBDAC_BIAS_LEVEL_UPPER   = 7'h03;
	localparam logic [6:0] LBDAC_BIAS_CEILING       = 7'h04;
	localparam logic [6:0] LBDAC_BIAS_STEP          = 7'h05;
	localparam logic [6:0] LBDAC_EQUALIZER_STRENGTH = 7'h06;
	localparam logic [6:0] LBDAC_EYE_CROSSING       = 7'h07;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int unsigned LBDAC_INVERT_POS    = 0;
	localparam int unsigned LBDAC_EQ_ON_POS     = 3;
	localparam int unsigned LBDAC_HARD_FLT_POS  = 0;
	localparam int unsigned LBDAC_SIG_PRES_POS  = 1;
	localparam int unsigned LBDAC_BIAS_WARN_POS = 0;
	localparam int unsigned LBDAC_STEP_MSB      = 4;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [7:0] LBDAC_TRANSMIT_CONTROL_RST  = 8'h00;
	localparam logic [8:0] LBDAC_BIAS_RST    = 9'h000;
	localparam logic [7:0] LBDAC_CEILING_RST = 8'h00;
	localparam logic [7:0] LBDAC_STEP_RST    = 8'h00;
	localparam logic [7:0] LBDAC_EQ_RST      = 8'h00;
	localparam logic [7:0] LBDAC_EYE_RST     = 8'h00;

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [2:0] {
		LBDAC_IDLE,
		LBDAC_CMD,
		LBDAC_WR,
		LBDAC_RD,
		LBDAC_END
	} lbdac_ser_e;

	typedef struct packed {
		logic [6:0] addr;
		logic [7:0] data;
	} lbdac_acc_s;

	typedef struct packed {
		logic       equalizer_on_bit;
		logic [7:0] equalizer_strength;
		logic       output_invert_bit;
		logic [7:0] eye_crossing_setting;
	} lbdac_cfg_s;

endpackage : lbdac_pkg

// >>> src/lbdac_ctrl.sv
// Purpose: serial register bank and bias DAC control of a laser driver
// Assumes: serial clock sampled by ref_clk; host edges far slower than it
// Notes:   access = 1 r/w bit, 7 address bits, 8 data bits, msb first
//
// Contract
// - disable low runs normally; high or open turns modulation and bias off
// - fault output latches high; clears only after condition gone and toggle
// - chip select high starts an access; low ends it and resets the fsm
// - serial data is open drain, with collision protection
// - bias setting is a nine-bit dac code, 200 uA per step
// - direct bias write loads code bits 8 down to 1
// - code bit 0 resets to zero and changes only by increment
// - ceiling register bounds the upper eight code bits on increment; direct bias writes are not checked against it
// - step register is eight bits; low five are signed -16..+15
// - increment beyond ceiling sets warning and leaves code unchanged
// - transmit control bit 3 enables equalizer with strength register
// - transmit control polarity bit selects inverted or true outputs
// - pulse width register selects output eye crossing point
// - readable status bit shows ac signal present at input
// - disable toggle clears the latched bits of both fault status registers and fault output; signal present stays live
// - power-on reset restores defaults and keeps laser off
`timescale 1ns/10ps
`default_nettype none

module lbdac_ctrl (
	input  wire logic              ref_clk,
	input  wire logic              resetn,
	input  wire logic              scl,
	input  wire logic              chip_select_line,
	input  wire logic              sda_i,
	output logic                   sda_o,
	output logic                   sda_oe,
	input  wire logic              disable_pin,
	input  wire logic              fault_cond,
	input  wire logic              input_signal_present,
	output logic                   laser_on,
	output logic                   fault_o,
	output logic                   fault_oe,
	output logic [8:0]             bias_code,
	output lbdac_pkg::lbdac_cfg_s  cfg
);
	import lbdac_pkg::*;

	// ************************************************************
	// input synchronisers
	// ************************************************************
	// order: scl, chip select, data, disable, fault, signal present
	logic [5:0] pin_m, pin_s;
	logic       scl_s, cs_s, sda_s, dis_s, flt_s, sig_s;
	logic       scl_p, dis_p;
	assign {scl_s, cs_s, sda_s, dis_s, flt_s, sig_s} = pin_s;
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pin_m <= 6'h0C;
			pin_s <= 6'h0C;
			scl_p <= 1'b0;
			dis_p <= 1'b1;
		end
		else
		begin
			pin_m <= {scl, chip_select_line, sda_i,
				disable_pin, fault_cond, input_signal_present};
			pin_s <= pin_m;
			scl_p <= scl_s;
			dis_p <= dis_s;
		end
	end

	// ************************************************************
	// state
	// ************************************************************
	lbdac_ser_e state_q, state_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] shf_q, shf_d;
	logic [6:0] addr_q, addr_d;
	logic       coll_q, coll_d;
	logic       sda_oe_q, sda_oe_d;
	logic [7:0] transmit_control_q, transmit_control_d;
	logic [8:0] bias_q, bias_d;
	logic [7:0] ceil_q, ceil_d;
	logic [7:0] step_q, step_d;
	logic [7:0] eqs_q, eqs_d;
	logic [7:0] eye_q, eye_d;
	logic       warn_q, warn_d;
	logic       fault_q, fault_d;
	logic       laser_q, laser_d;
	logic       scl_rise, scl_fall, dis_edge, wr_go, step_err;
	logic [7:0] byte_in;
	logic [10:0] sum;
	lbdac_acc_s wacc;
	function automatic logic [7:0] rd_mux(input logic [6:0] a);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			LBDAC_TRANSMIT_CONTROL:   v = transmit_control_q;
			LBDAC_FAULT_STATUS_ONE:
			begin
				v[LBDAC_HARD_FLT_POS] = fault_q;
				v[LBDAC_SIG_PRES_POS] = sig_s;
			end
			LBDAC_FAULT_STATUS_TWO:   v[LBDAC_BIAS_WARN_POS] = warn_q;
			LBDAC_BIAS_LEVEL_UPPER:   v = bias_q[8:1];
			LBDAC_BIAS_CEILING:       v = ceil_q;
			LBDAC_BIAS_STEP:          v = step_q;
			LBDAC_EQUALIZER_STRENGTH: v = eqs_q;
			LBDAC_EYE_CROSSING:       v = eye_q;
			default:                  v = 8'h00;
		endcase
		return v;
	endfunction : rd_mux

	// ************************************************************
	// next state
	// ************************************************************
	always_comb
	begin
		scl_rise = scl_s & ~scl_p;
		scl_fall = ~scl_s & scl_p;
		dis_edge = dis_s ^ dis_p;
		byte_in  = {shf_q[6:0], sda_s};
		state_d  = state_q;
		cnt_d    = cnt_q;
		shf_d    = shf_q;
		addr_d   = addr_q;
		coll_d   = coll_q;
		sda_oe_d = sda_oe_q;
		wr_go    = 1'b0;
		wacc     = '{addr: addr_q, data: byte_in};
		case (state_q)
			LBDAC_IDLE:
			begin
				if (cs_s)
				begin
					state_d = LBDAC_CMD;
					coll_d  = 1'b0;
				end
			end
			LBDAC_CMD:
			begin
				if (scl_rise)
				begin
					shf_d = byte_in;
					cnt_d = cnt_q + 4'h1;
					if (cnt_q == 4'h7)
					begin
						addr_d = byte_in[6:0];
						cnt_d  = 4'h0;
						if (byte_in[7])
						begin
							shf_d    = rd_mux(byte_in[6:0]);
							sda_oe_d = ~shf_d[7];
							state_d  = LBDAC_RD;
						end
						else
							state_d = LBDAC_WR;
					end
				end
			end
			LBDAC_WR:
			begin
				if (scl_rise)
				begin
					shf_d = byte_in;
					cnt_d = cnt_q + 4'h1;
					if (cnt_q == 4'h7)
					begin
						wr_go   = 1'b1;
						state_d = LBDAC_END;
					end
				end
			end
			LBDAC_RD:
			begin
				// released bit seen low: another driver owns the line
				if (scl_rise && !sda_oe_q && !sda_s)
				begin
					coll_d   = 1'b1;
					sda_oe_d = 1'b0;
				end
				else if (scl_fall)
				begin
					shf_d = {shf_q[6:0], 1'b0};
					cnt_d = cnt_q + 4'h1;
					if (cnt_q == 4'h7)
					begin
						sda_oe_d = 1'b0;
						state_d  = LBDAC_END;
					end
					else
						sda_oe_d = ~shf_q[6] & ~coll_q;
				end
			end
			LBDAC_END:   state_d = LBDAC_END;
			default:     state_d = LBDAC_IDLE;
		endcase
		if (!cs_s)
		begin
			state_d  = LBDAC_IDLE;
			sda_oe_d = 1'b0;
			cnt_d    = 4'h0;
		end
		// register file
		transmit_control_d = transmit_control_q;
		bias_d   = bias_q;
		ceil_d   = ceil_q;
		step_d   = step_q;
		eqs_d    = eqs_q;
		eye_d    = eye_q;
		sum = {2'b00, bias_q}
			+ {{6{wacc.data[LBDAC_STEP_MSB]}}, wacc.data[4:0]};
		step_err = sum[10] | sum[9] | (sum[8:1] > ceil_q);
		warn_d = warn_q & ~dis_edge;
		if (wr_go)
		begin
			case (wacc.addr)
				LBDAC_TRANSMIT_CONTROL:   transmit_control_d = wacc.data;
				LBDAC_BIAS_LEVEL_UPPER:   bias_d[8:1] = wacc.data;
				LBDAC_BIAS_CEILING:       ceil_d = wacc.data;
				LBDAC_BIAS_STEP:
				begin
					step_d = wacc.data;
					if (step_err)
						warn_d = 1'b1;
					else
						bias_d = sum[8:0];
				end
				LBDAC_EQUALIZER_STRENGTH: eqs_d = wacc.data;
				LBDAC_EYE_CROSSING:       eye_d = wacc.data;
				default:                  transmit_control_d = transmit_control_q;
			endcase
		end
		// fault latch: set wins over the disable-toggle clear
		fault_d = flt_s | (fault_q & ~dis_edge);
		laser_d = ~dis_s & ~fault_q & ~flt_s;
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_q  <= LBDAC_IDLE;
			cnt_q    <= 4'h0;
			shf_q    <= 8'h00;
			addr_q   <= 7'h00;
			coll_q   <= 1'b0;
			sda_oe_q <= 1'b0;
			transmit_control_q <= LBDAC_TRANSMIT_CONTROL_RST;
			bias_q   <= LBDAC_BIAS_RST;
			ceil_q   <= LBDAC_CEILING_RST;
			step_q   <= LBDAC_STEP_RST;
			eqs_q    <= LBDAC_EQ_RST;
			eye_q    <= LBDAC_EYE_RST;
			warn_q   <= 1'b0;
			fault_q  <= 1'b0;
			laser_q  <= 1'b0;
		end
		else
		begin
			state_q  <= state_d;
			cnt_q    <= cnt_d;
			shf_q    <= shf_d;
			addr_q   <= addr_d;
			coll_q   <= coll_d;
			sda_oe_q <= sda_oe_d;
			transmit_control_q <= transmit_control_d;
			bias_q   <= bias_d;
			ceil_q   <= ceil_d;
			step_q   <= step_d;
			eqs_q    <= eqs_d;
			eye_q    <= eye_d;
			warn_q   <= warn_d;
			fault_q  <= fault_d;
			laser_q  <= laser_d;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	// open-drain pins only ever pull low
	assign sda_o     = 1'b0;
	assign sda_oe    = sda_oe_q;
	assign fault_o   = 1'b0;
	assign fault_oe  = ~fault_q;
	assign laser_on  = laser_q;
	assign bias_code = bias_q;
	assign cfg = {transmit_control_q[LBDAC_EQ_ON_POS], eqs_q,
		transmit_control_q[LBDAC_INVERT_POS], eye_q};

endmodule : lbdac_ctrl

`default_nettype wire

// >>> dv/lbdac_host.sv
// Purpose: host controller model on the three-wire serial port
// Assumes: scl stands low outside frames, 160 ns period
// Notes:   sda_h high releases the wire to its pull-up
`timescale 1ns/10ps
`default_nettype none
module lbdac_host (
	input  wire logic ref_clk,
	input  wire logic sda,
	output var  logic scl,
	output var  logic cs,
	output var  logic sda_h
);
	// ****************************************
	// access of n scl pulses, msb first
	// ****************************************
	initial
	begin
		scl = 1'b0;
		cs = 1'b0;
		sda_h = 1'b1;
	end
	task automatic half;
		repeat (4) @(negedge ref_clk);
	endtask : half
	task automatic xfer(input logic rw, input logic [6:0] a,
		input logic [7:0] d, input int n, output logic [7:0] q);
		logic [15:0] w;
		w = {rw, a, d};
		q = 8'h00;
		cs = 1'b1;
		repeat (7) half();
		for (int i = 15; i > 15 - n; i--)
		begin
			sda_h = (rw && i < 8) ? 1'b1 : w[i];
			half();
			scl = 1'b1;
			// read bit k stands through the high phase of pulse k+1
			repeat (2) @(negedge ref_clk);
			if (rw && i == 8)
				sda_h = 1'b1;
			repeat (2) @(negedge ref_clk);
			if (rw && i > 0 && i < 9)
				q[i - 1] = sda;
			scl = 1'b0;
		end
		sda_h = 1'b1;
		repeat (7) half();
		cs = 1'b0;
		repeat (7) half();
	endtask : xfer
endmodule : lbdac_host
`default_nettype wire

// >>> dv/lbdac_ctrl_asserts.sv
// Purpose: port-level checker of the bias dac control block
// Assumes: one clock domain, ref_clk
// Notes:   bound into lbdac_ctrl below
`timescale 1ns/10ps
`default_nettype none
module lbdac_ctrl_asserts (
	input wire logic                  ref_clk,
	input wire logic                  resetn,
	input wire logic                  scl,
	input wire logic                  chip_select_line,
	input wire logic                  sda_i,
	input wire logic                  sda_o,
	input wire logic                  sda_oe,
	input wire logic                  disable_pin,
	input wire logic                  fault_cond,
	input wire logic                  input_signal_present,
	input wire logic                  laser_on,
	input wire logic                  fault_o,
	input wire logic                  fault_oe,
	input wire logic [8:0]            bias_code,
	input wire lbdac_pkg::lbdac_cfg_s cfg
);
	import lbdac_pkg::*;
	// ****************************************
	// cycles since the disable pin last moved
	// ****************************************
	logic [3:0] since_q, since_d;
	logic       dis_q, dis_d;
	always_comb
	begin
		dis_d = disable_pin;
		since_d = since_q + {3'h0, since_q != 4'hF};
		if (disable_pin != dis_q)
			since_d = 4'h0;
	end
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			dis_q <= 1'b1;
			since_q <= 4'hF;
		end
		else
		begin
			dis_q <= dis_d;
			since_q <= since_d;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	sequence dis_held; disable_pin[*6]; endsequence
	sequence run_ok; (!disable_pin && !fault_cond && fault_oe)[*6];
	endsequence
	sda_zero_a: assert property (!sda_o && !fault_o)
		else $error("open drain output driven high");
	laser_off_a: assert property (dis_held |-> !laser_on)
		else $error("laser on while disabled");
	laser_run_a: assert property (run_ok |-> laser_on)
		else $error("laser off in normal operation");
	fault_set_a: assert property (fault_cond[*6] |-> !fault_oe && !laser_on)
		else $error("fault not flagged");
	fault_clear_a: assert property ($rose(fault_oe) |-> since_q < 4'h8)
		else $error("fault cleared without disable toggle");
	sda_idle_a: assert property (!chip_select_line[*5] |-> !sda_oe)
		else $error("data wire driven outside frame");
	frame_hold_a: assert property (!chip_select_line[*5] |->
		$stable({cfg, bias_code})) else $error("register moved outside frame");
	step_bound_a: assert property ($changed(bias_code[0]) |->
		9'(bias_code - $past(bias_code) + 9'h010) < 9'h020)
		else $error("code lsb moved by more than a step");
endmodule : lbdac_ctrl_asserts
bind lbdac_ctrl lbdac_ctrl_asserts chk_i (.ref_clk, .resetn, .scl,
	.chip_select_line, .sda_i, .sda_o, .sda_oe, .disable_pin, .fault_cond,
	.input_signal_present, .laser_on, .fault_o, .fault_oe, .bias_code, .cfg);
`default_nettype wire

// >>> dv/tb_laser_bias_dac_control.sv
// Purpose: self-checking bench of the laser bias dac control block
// Assumes: host model makes every serial access
// Notes:   random steps are checked against a bench model of the code
`timescale 1ns/10ps
`default_nettype none
module tb_laser_bias_dac_control;
	import lbdac_pkg::*;
	logic       ref_clk, resetn, scl, cs, sda_h, sda, dis, flt, sig, e, w;
	logic       sda_o, sda_oe, laser_on, fault_o, fault_oe;
	logic [8:0] bias_code, x;
	logic [7:0] q, s;
	lbdac_cfg_s cfg;
	int         n_errors, total_checks, seed;
	assign sda = sda_h & ~sda_oe;
	lbdac_ctrl dut (.ref_clk(ref_clk), .resetn(resetn), .scl(scl),
		.chip_select_line(cs), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
		.disable_pin(dis), .fault_cond(flt), .input_signal_present(sig),
		.laser_on(laser_on), .fault_o(fault_o), .fault_oe(fault_oe),
		.bias_code(bias_code), .cfg(cfg));
	lbdac_host host (.ref_clk(ref_clk), .sda(sda), .scl(scl), .cs(cs),
		.sda_h(sda_h));
	// ****************************************
	// helpers
	// ****************************************
	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	initial
	begin
		repeat (100000) @(posedge ref_clk);
		n_errors++;
		$display("MISMATCH %0t run timed out", $time);
		print_verdict();
	end
	task automatic chk(input logic [8:0] g, input logic [8:0] x, string m);
		total_checks++;
		if (g !== x)
		begin
			n_errors++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, g, x);
		end
	endtask : chk
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		host.xfer(1'b0, a, d, 16, q);
	endtask : wr
	task automatic rd(input logic [6:0] a, input logic [7:0] x, string m);
		host.xfer(1'b1, a, 8'h00, 16, q);
		chk({1'b0, q}, {1'b0, x}, m);
	endtask : rd
	task automatic pause;
		repeat (8) @(negedge ref_clk);
	endtask : pause
	function automatic logic [9:0] step_model(input logic [8:0] c,
		input logic [7:0] st, input logic [7:0] lim);
		logic [9:0] sum;
		sum = {1'b0, c} + {{5{st[4]}}, st[4:0]};
		if (sum[9] || sum[8:1] > lim)
			return {1'b1, c};
		return {1'b0, sum[8:0]};
	endfunction : step_model
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : print_verdict
	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		seed = 57912;
		{n_errors, total_checks} = 0;
		{resetn, flt, sig, w} = 4'h0;
		dis = 1'b1;
		repeat (5) @(negedge ref_clk);
		resetn = 1'b1;
		chk(bias_code, LBDAC_BIAS_RST, "reset code");
		dis = 1'b0;
		pause();
		chk({8'h00, laser_on}, 9'h001, "laser on");
		wr(LBDAC_BIAS_CEILING, 8'h10);
		wr(LBDAC_BIAS_LEVEL_UPPER, 8'h0F);
		chk(bias_code, 9'h01E, "direct write");
		rd(LBDAC_BIAS_LEVEL_UPPER, 8'h0F, "readback");
		host.xfer(1'b0, LBDAC_BIAS_LEVEL_UPPER, 8'h55, 12, q);
		chk(bias_code, 9'h01E, "aborted write");
		x = 9'h01E;
		for (int i = 0; i < 24; i++)
		begin
			s = (i == 0) ? 8'h01 : (i < 3) ? 8'h10 : 8'($random(seed));
			{e, x} = step_model(x, s, 8'h10);
			w |= e;
			wr(LBDAC_BIAS_STEP, s);
			chk(bias_code, x, "step");
		end
		wr(LBDAC_BIAS_CEILING, 8'hFF);
		wr(LBDAC_BIAS_LEVEL_UPPER, 8'hFF);
		x = {8'hFF, x[0]};
		chk(bias_code, x, "lsb kept");
		{e, x} = step_model(x, 8'h0F, 8'hFF);
		w |= e;
		wr(LBDAC_BIAS_STEP, 8'h0F);
		chk(bias_code, x, "overflow step");
		rd(LBDAC_FAULT_STATUS_TWO, {7'h00, w}, "warning");
		$display("done: bias steps");
		s = 8'($random(seed));
		wr(LBDAC_TRANSMIT_CONTROL, 8'h09);
		wr(LBDAC_EQUALIZER_STRENGTH, s);
		wr(LBDAC_EYE_CROSSING, ~s);
		chk({7'h00, cfg.equalizer_on_bit, cfg.output_invert_bit}, 9'h003,
			"control bits");
		chk({1'b0, cfg.equalizer_strength}, {1'b0, s}, "eq");
		chk({1'b0, cfg.eye_crossing_setting}, {1'b0, ~s}, "eye");
		rd(7'h7F, 8'h00, "unmapped");
		sig = 1'b1;
		rd(LBDAC_FAULT_STATUS_ONE, 8'h02, "signal present");
		$display("done: config");
		flt = 1'b1;
		pause();
		flt = 1'b0;
		pause();
		chk({7'h00, fault_oe, laser_on}, 9'h000, "fault held");
		rd(LBDAC_FAULT_STATUS_ONE, 8'h03, "fault latch");
		dis = 1'b1;
		pause();
		dis = 1'b0;
		pause();
		chk({7'h00, fault_oe, laser_on}, 9'h003, "fault clear");
		rd(LBDAC_FAULT_STATUS_TWO, 8'h00, "warning clear");
		$display("done: fault");
		dis = 1'b1;
		pause();
		chk({8'h00, laser_on}, 9'h000, "disabled");
		resetn = 1'b0;
		@(negedge ref_clk);
		resetn = 1'b1;
		chk(bias_code | {1'b0, cfg[7:0]}, 9'h000, "mid-run reset");
		$display("done: reset");
		print_verdict();
	end
endmodule : tb_laser_bias_dac_control
`default_nettype wire
